// File: serial_unit_defines.svh
`ifndef SERIAL_UNIT_DEFINES_SVH
`define SERIAL_UNIT_DEFINES_SVH

// register byte offsets
`define SU_CTRL_OFS 8'h00
`define SU_STAT_OFS 8'h04
`define SU_TXDATA_OFS 8'h08
`define SU_RXDATA_OFS 8'h0c
`define SU_RATE_OFS 8'h10

// reset values
`define SU_CTRL_RST 8'h00
`define SU_STAT_RST 7'h21
`define SU_RATE_RST 8'h04

// axi responses
`define SU_RESP_OKAY 2'h0
`define SU_RESP_SLVERR 2'h2

// clocked synchronous frame: last bit index
`define SU_SYNC_LAST 3'h7

// smart card timing in half bit periods from the start bit edge
`define SU_H_DATA_FIRST 5'h03
`define SU_H_DATA_LAST 5'h11
`define SU_H_PARITY_OUT 5'h12
`define SU_H_PARITY_SAMPLE 5'h13
`define SU_H_PARITY_END 5'h14
`define SU_H_ERR_START 5'h15
`define SU_H_ERR_SAMPLE 5'h16
`define SU_H_ERR_END 5'h17
`define SU_H_GUARD_END 5'h18
`define SU_H_RETRY 5'h1c

`endif

// File: serial_unit_pkg.sv
package serial_unit_pkg;

  // engine states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SYNC = 4'b0010,
    ST_CARD_TX = 4'b0100,
    ST_CARD_RX = 4'b1000
  } state_e;

  // control register fields, bit 7 down to bit 0
  typedef struct packed {
    logic dmaAuto;
    logic cardMode;
    logic extClk;
    logic txDoneIrqEn;
    logic rxIrqEn;
    logic txIrqEn;
    logic rxEn;
    logic txEn;
  } ctrl_s;

  // status register fields, bit 6 down to bit 0
  typedef struct packed {
    logic ers;
    logic tx_done_flag;
    logic parity_error_flag;
    logic framing_error_flag;
    logic overrun_flag;
    logic rx_buffer_full_flag;
    logic tx_buffer_empty_flag;
  } stat_s;

  // synchronised pin levels
  typedef struct packed {
    logic sck;
    logic rxd;
  } pins_s;

endpackage : serial_unit_pkg

// File: pin_sync.sv
`timescale 1ns/1ns
module pin_sync
  import serial_unit_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rstn, // async reset, active low
  input wire pins_s pinIn, // raw pin levels
  output pins_s pinOut // levels after two flops
);

  localparam int WIDTH = $bits(pins_s);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  // two flops per pin, idle level high
  genvar i;
  for (i = 0; i < WIDTH; i++) begin : g_bit
    always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
        stage1[i] <= 1'b1;
        stage2[i] <= 1'b1;
      end else begin
        stage1[i] <= pinIn[i];
        stage2[i] <= stage1[i];
      end
    end
  end

  assign pinOut = stage2;

endmodule : pin_sync

// File: serial_unit.sv
`timescale 1ns/1ns
`include "serial_unit_defines.svh"
module serial_unit
  import serial_unit_pkg::*;
(
  input wire logic ref_clk, // 50 MHz clock
  input wire logic rstn, // async reset, active low
  input wire logic [31:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // write byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [31:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire logic sckIn, // serial clock pin level
  output logic sckOut, // serial clock drive level
  output logic sckOeN, // serial clock drive enable, low drives
  input wire logic rxdIn, // receive data pin level
  output logic txdOut, // transmit data drive level
  output logic txdOeN, // transmit data drive enable, low drives
  output logic txEmptyIrq, // transmit buffer empty request
  output logic txDoneIrq, // transmit done request
  output logic rxFullIrq, // receive buffer full request
  output logic rxErrorIrq // receive error request
);

  ctrl_s ctrl;
  stat_s stat;
  state_e state;
  pins_s pinRaw;
  pins_s pinS;
  logic [7:0] txBuf;
  logic [7:0] rxBuf;
  logic [7:0] rate;
  logic [7:0] txShift;
  logic [7:0] rxShift;
  logic [7:0] divCnt;
  logic [2:0] bitCnt;
  logic [4:0] halfCnt;
  logic sckGen;
  logic sckPrev;
  logic rxPrev;
  logic reloadPend;
  logic cardErr;
  logic txdLevel;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  assign pinRaw = '{sck: sckIn, rxd: rxdIn};

  pin_sync u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pinIn(pinRaw),
    .pinOut(pinS)
  );

  ////////////////////////////////////////////////////////////////////////
  // register bus decode
  wire wrDo = awready & awvalid & wvalid;
  wire rdDo = arready & arvalid;
  wire [5:0] wrIdx = awaddr[7:2];
  wire [5:0] rdIdx = araddr[7:2];
  wire wrHigh = |awaddr[31:8];
  wire rdHigh = |araddr[31:8];
  wire wrCtrl = wrDo & wstrb[0] & !wrHigh & (wrIdx == `SU_CTRL_OFS >> 2);
  wire wrStat = wrDo & wstrb[0] & !wrHigh & (wrIdx == `SU_STAT_OFS >> 2);
  wire wrTx = wrDo & wstrb[0] & !wrHigh & (wrIdx == `SU_TXDATA_OFS >> 2);
  wire wrRate = wrDo & wstrb[0] & !wrHigh & (wrIdx == `SU_RATE_OFS >> 2);
  wire rdRx = rdDo & !rdHigh & (rdIdx == `SU_RXDATA_OFS >> 2);
  wire wrMapped = !wrHigh & ((wrIdx == `SU_CTRL_OFS >> 2) | (wrIdx == `SU_STAT_OFS >> 2) |
                  (wrIdx == `SU_TXDATA_OFS >> 2) | (wrIdx == `SU_RXDATA_OFS >> 2) |
                  (wrIdx == `SU_RATE_OFS >> 2));
  wire rdMapped = !rdHigh & ((rdIdx == `SU_CTRL_OFS >> 2) | (rdIdx == `SU_STAT_OFS >> 2) |
                  (rdIdx == `SU_TXDATA_OFS >> 2) | (rdIdx == `SU_RXDATA_OFS >> 2) |
                  (rdIdx == `SU_RATE_OFS >> 2));
  wire [31:0] rdMux =
    (rdIdx == `SU_CTRL_OFS >> 2) ? {24'h000000, ctrl} :
    (rdIdx == `SU_STAT_OFS >> 2) ? {25'h0000000, stat} :
    (rdIdx == `SU_TXDATA_OFS >> 2) ? {24'h000000, txBuf} :
    (rdIdx == `SU_RXDATA_OFS >> 2) ? {24'h000000, rxBuf} :
    {24'h000000, rate};

  ////////////////////////////////////////////////////////////////////////
  // clock edges and event decode
  wire inSync = (state == ST_SYNC);
  wire inCard = (state == ST_CARD_TX) | (state == ST_CARD_RX);
  wire tick = (divCnt == rate);
  wire extFall = sckPrev & !pinS.sck;
  wire extRise = !sckPrev & pinS.sck;
  wire sckFall = ctrl.extClk ? extFall : (tick & sckGen);
  wire sckRise = ctrl.extClk ? extRise : (tick & !sckGen);
  wire errAny = stat.overrun_flag | stat.framing_error_flag | stat.parity_error_flag;
  wire txGo = ctrl.txEn & !stat.tx_buffer_empty_flag & !errAny;
  wire rxRun = ctrl.rxEn & !errAny;
  wire idleTx = (state == ST_IDLE) & txGo;
  wire idleCardRx = (state == ST_IDLE) & !txGo & ctrl.cardMode & rxRun & rxPrev & !pinS.rxd;
  wire frameEnd = inSync & sckRise & (bitCnt == `SU_SYNC_LAST);
  wire syncReload = frameEnd & reloadPend;
  wire syncDone = frameEnd & !reloadPend & ctrl.txEn;
  // receive-only runs frames back to back while the receive buffer has room; with the transmitter on, each write paces one frame
  wire syncStay = syncReload | (rxRun & !ctrl.txEn & !stat.rx_buffer_full_flag);
  wire syncAbort = inSync & !ctrl.txEn & !ctrl.rxEn;
  wire loadTx = idleTx | syncReload;
  wire [4:0] halfAhead = halfCnt + 5'h01;
  wire cardTick = inCard & tick;
  wire ctx = (state == ST_CARD_TX) & cardTick;
  wire crx = (state == ST_CARD_RX) & cardTick;
  wire [9:0] cardFrame = {^txShift, txShift, 1'b0};
  wire cardErrSeen = ctx & (halfAhead == `SU_H_ERR_SAMPLE) & !pinS.rxd;
  wire cardDone = ctx & (halfAhead == `SU_H_GUARD_END) & !cardErr;
  wire cardRetry = ctx & (halfAhead == `SU_H_RETRY) & cardErr;
  wire cardParity = crx & (halfAhead == `SU_H_PARITY_SAMPLE);
  wire cardPerr = cardParity & (pinS.rxd ^ (^rxShift));
  wire cardRxEnd = crx & (halfAhead == `SU_H_GUARD_END);
  wire [2:0] cardRxIdx = 3'(halfAhead[4:1] - 4'h1);
  wire syncStore = frameEnd & rxRun & !stat.rx_buffer_full_flag;
  wire syncOver = frameEnd & rxRun & stat.rx_buffer_full_flag;
  wire [7:0] syncByte = {pinS.rxd, rxShift[6:0]}; // last bit lands on the storing edge
  wire cardStore = cardParity & !cardPerr & !stat.rx_buffer_full_flag;
  wire cardOver = cardParity & !cardPerr & stat.rx_buffer_full_flag;

  ////////////////////////////////////////////////////////////////////////
  // status flag set and clear terms, a set wins over a clear
  wire dmaTx = wrTx & ctrl.dmaAuto;
  wire dmaRx = rdRx & ctrl.dmaAuto;
  wire [6:0] swClr = wrStat ? ~wdata[6:0] : 7'h00;
  stat_s hwSet;
  stat_s hwClr;
  assign hwSet = '{ers: cardErrSeen,
                   tx_done_flag: syncDone | cardDone | !ctrl.txEn,
                   parity_error_flag: cardPerr,
                   framing_error_flag: 1'b0,
                   overrun_flag: syncOver | cardOver,
                   rx_buffer_full_flag: syncStore | cardStore,
                   tx_buffer_empty_flag: loadTx | !ctrl.txEn};
  assign hwClr = '{ers: swClr[6],
                   tx_done_flag: swClr[5] | swClr[0] | dmaTx,
                   parity_error_flag: swClr[4],
                   framing_error_flag: swClr[3],
                   overrun_flag: swClr[2],
                   rx_buffer_full_flag: swClr[1] | dmaRx,
                   tx_buffer_empty_flag: swClr[0] | dmaTx};

  // flags and software registers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stat <= `SU_STAT_RST;
      ctrl <= `SU_CTRL_RST;
      rate <= `SU_RATE_RST;
      txBuf <= 8'h00;
    end else begin
      stat <= (stat & ~hwClr) | hwSet;
      if (wrCtrl) ctrl <= wdata[7:0];
      if (wrRate) rate <= wdata[7:0];
      if (wrTx) txBuf <= wdata[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel: address and data taken together
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `SU_RESP_OKAY;
    end else begin
      awready <= awvalid & wvalid & !awready & !bvalid;
      wready <= awvalid & wvalid & !awready & !bvalid;
      if (wrDo) begin
        bvalid <= 1'b1;
        bresp <= wrMapped ? `SU_RESP_OKAY : `SU_RESP_SLVERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // axi4-lite read channel
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `SU_RESP_OKAY;
    end else begin
      arready <= arvalid & !arready & !rvalid;
      if (rdDo) begin
        rvalid <= 1'b1;
        rdata <= rdMapped ? rdMux : 32'h00000000;
        rresp <= rdMapped ? `SU_RESP_OKAY : `SU_RESP_SLVERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bit rate divider and generated serial clock
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      divCnt <= 8'h00;
      sckGen <= 1'b1;
      sckPrev <= 1'b1;
      rxPrev <= 1'b1;
    end else begin
      divCnt <= (tick | (state == ST_IDLE)) ? 8'h00 : divCnt + 8'h01;
      if (!inSync | ctrl.extClk) sckGen <= 1'b1;
      else if (tick) sckGen <= !sckGen;
      sckPrev <= pinS.sck;
      rxPrev <= pinS.rxd;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transfer engine
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      txShift <= 8'h00;
      rxShift <= 8'h00;
      rxBuf <= 8'h00;
      bitCnt <= 3'h0;
      halfCnt <= 5'h00;
      reloadPend <= 1'b0;
      cardErr <= 1'b0;
      txdLevel <= 1'b1;
    end else begin
      if (loadTx) txShift <= txBuf;
      if (cardStore) rxBuf <= rxShift;
      if (syncStore) rxBuf <= syncByte;
      unique case (state)
        ST_IDLE: begin
          bitCnt <= 3'h0;
          halfCnt <= 5'h00;
          cardErr <= 1'b0;
          reloadPend <= 1'b0;
          if (idleTx & ctrl.cardMode) begin
            txdLevel <= 1'b0;
            state <= ST_CARD_TX;
          end else if (idleTx) begin
            txdLevel <= txBuf[0];
            state <= ST_SYNC;
          end else if (idleCardRx) begin
            state <= ST_CARD_RX;
          end else if (!ctrl.cardMode & rxRun & !ctrl.txEn) begin
            state <= ST_SYNC;
          end
        end
        ST_SYNC: begin
          if (sckFall & ctrl.txEn) txdLevel <= txShift[bitCnt];
          if (sckFall & (bitCnt == `SU_SYNC_LAST)) reloadPend <= txGo;
          if (sckRise) rxShift[bitCnt] <= pinS.rxd;
          if (sckRise) bitCnt <= bitCnt + 3'h1;
          if (syncAbort | (frameEnd & !syncStay)) state <= ST_IDLE;
        end
        ST_CARD_TX: begin
          if (cardTick) halfCnt <= halfAhead;
          if (ctx & !halfAhead[0] & (halfAhead <= `SU_H_PARITY_OUT)) begin
            txdLevel <= cardFrame[halfAhead[4:1]];
          end
          if (ctx & (halfAhead == `SU_H_PARITY_END)) txdLevel <= 1'b1;
          if (cardErrSeen) cardErr <= 1'b1;
          if (cardDone | !ctrl.txEn) state <= ST_IDLE;
          if (cardRetry) begin
            halfCnt <= 5'h00;
            cardErr <= 1'b0;
            txdLevel <= 1'b0;
          end
        end
        ST_CARD_RX: begin
          if (cardTick) halfCnt <= halfAhead;
          if (crx & halfAhead[0] & (halfAhead >= `SU_H_DATA_FIRST) &
              (halfAhead <= `SU_H_DATA_LAST)) begin
            rxShift[cardRxIdx] <= pinS.rxd;
          end
          if (cardPerr) cardErr <= 1'b1;
          if (crx & (halfAhead == `SU_H_ERR_START) & cardErr) txdLevel <= 1'b0;
          if (crx & (halfAhead == `SU_H_ERR_END)) txdLevel <= 1'b1;
          if (cardRxEnd | !ctrl.rxEn) state <= ST_IDLE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered pin drives and interrupt request levels
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sckOut <= 1'b1;
      sckOeN <= 1'b1;
      txdOut <= 1'b1;
      txdOeN <= 1'b1;
      txEmptyIrq <= 1'b0;
      txDoneIrq <= 1'b0;
      rxFullIrq <= 1'b0;
      rxErrorIrq <= 1'b0;
    end else begin
      sckOut <= sckGen;
      sckOeN <= ctrl.extClk;
      txdOut <= ctrl.cardMode ? 1'b0 : txdLevel;
      txdOeN <= ctrl.cardMode ? txdLevel : !ctrl.txEn;
      txEmptyIrq <= ctrl.txIrqEn & stat.tx_buffer_empty_flag;
      txDoneIrq <= ctrl.txDoneIrqEn & stat.tx_done_flag;
      rxFullIrq <= ctrl.rxIrqEn & stat.rx_buffer_full_flag;
      rxErrorIrq <= ctrl.rxIrqEn & (errAny | stat.ers);
    end
  end

endmodule : serial_unit

// File: serial_unit_monitor.sv
`timescale 1ns/1ns
`include "serial_unit_defines.svh"
module serial_unit_monitor
  import serial_unit_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rstn, // reset, active low
  input wire logic [31:0] awaddr, // write address
  input wire logic awvalid, // aw valid
  input wire logic awready, // aw ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // strobes
  input wire logic wvalid, // w valid
  input wire logic wready, // w ready
  input wire logic bvalid, // b valid
  input wire logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic rvalid, // r valid
  input wire logic sckOut, // clock drive level
  input wire logic sckOeN, // clock enable, low drives
  input wire logic txdOut, // data drive level
  input wire logic txEmptyIrq, // empty request
  input wire logic txDoneIrq, // done request
  input wire logic rxFullIrq, // full request
  input wire logic rxErrorIrq // error request
);
  logic [7:0] ctrlSh;
  logic [7:0] rateSh;
  logic [8:0] lowCnt;
  logic wrTake;
  ////////////////////////////////////////////////////////////////
  // shadows of control and rate, taken at the write handshake
  assign wrTake = awvalid && awready && wstrb[0] && (awaddr[31:8] == 24'h000000);
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      ctrlSh <= `SU_CTRL_RST;
      rateSh <= `SU_RATE_RST;
    end else if (wrTake && awaddr[7:0] == `SU_CTRL_OFS) begin
      ctrlSh <= wdata[7:0];
    end else if (wrTake && awaddr[7:0] == `SU_RATE_OFS) begin
      rateSh <= wdata[7:0];
    end
  end
  // length of the current low phase of the serial clock
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) lowCnt <= 9'h000;
    else if (sckOut) lowCnt <= 9'h000;
    else lowCnt <= lowCnt + 9'h001;
  end
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  a_sck_low_width: assert property ($rose(sckOut) && !sckOeN |-> lowCnt == {1'b0, rateSh} + 9'h001)
    else $error("serial clock low phase has the wrong length");
  a_data_on_fall: assert property ($changed(txdOut) |-> !$rose(sckOut) && (sckOut || $fell(sckOut)))
    else $error("transmit data changed away from a falling clock edge");
  a_done_parks: assert property ($rose(txDoneIrq) |-> sckOut && $stable(txdOut))
    else $error("done request without parked clock and held data");
  a_empty_irq_gate: assert property (txEmptyIrq |-> $past(ctrlSh[2], 1))
    else $error("empty request while its enable is clear");
  a_done_irq_gate: assert property (txDoneIrq |-> $past(ctrlSh[4], 1))
    else $error("done request while its enable is clear");
  a_rx_irq_gate: assert property (rxFullIrq || rxErrorIrq |-> $past(ctrlSh[3], 1))
    else $error("receive request while its enable is clear");
  a_write_ready: assert property (awvalid && wvalid && !awready && !bvalid |=> awready && wready)
    else $error("write not taken one cycle after both valids");
  a_write_resp: assert property (awvalid && awready |=> bvalid && !awready)
    else $error("write response missing after handshake");
  a_read_resp: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read data missing after address handshake");
endmodule : serial_unit_monitor

bind serial_unit serial_unit_monitor serial_unit_monitor_i (
  .ref_clk(ref_clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .sckOut(sckOut), .sckOeN(sckOeN),
  .txdOut(txdOut), .txEmptyIrq(txEmptyIrq), .txDoneIrq(txDoneIrq), .rxFullIrq(rxFullIrq),
  .rxErrorIrq(rxErrorIrq)
);

// File: serial_peer.sv
`timescale 1ns/1ns
module serial_peer (
  input wire logic rstn, // reset, active low
  input wire logic sck, // serial clock line
  input wire logic txd, // data line from the unit
  output logic rxd, // data line to the unit
  input wire logic [7:0] sendByte, // byte offered each frame
  output logic [7:0] lastByte, // last byte captured
  output logic [7:0] prevByte // byte before that
);
  logic [7:0] outSh;
  logic [7:0] inSh;
  int outIdx;
  int inIdx;
  initial begin
    rxd = 1'b1;
    outSh = 8'h00;
    inSh = 8'h00;
    lastByte = 8'h00;
    prevByte = 8'h00;
    outIdx = 0;
    inIdx = 0;
  end
  // next bit leaves on each falling edge, lsb first
  always @(negedge sck) begin
    if (rstn) begin
      if (outIdx == 0) outSh = sendByte;
      rxd <= outSh[outIdx];
      outIdx = (outIdx + 1) % 8;
    end
  end
  // capture on rising edges; after the eighth bit the line turns meaningless
  always @(posedge sck) begin
    if (rstn) begin
      inSh = {txd, inSh[7:1]};
      inIdx = inIdx + 1;
      if (inIdx == 8) begin
        prevByte <= lastByte;
        lastByte <= inSh;
        inIdx = 0;
        rxd <= ~rxd;
      end
    end
  end
endmodule : serial_peer

// File: serial_unit_tb_top.sv
`timescale 1ns/1ns
`include "serial_unit_defines.svh"
module serial_unit_tb_top import serial_unit_pkg::*;;
  localparam logic [31:0] ctrlA = {24'h000000, `SU_CTRL_OFS};
  localparam logic [31:0] statA = {24'h000000, `SU_STAT_OFS};
  localparam logic [31:0] txA = {24'h000000, `SU_TXDATA_OFS};
  localparam logic [31:0] rxA = {24'h000000, `SU_RXDATA_OFS};
  localparam logic [31:0] rateA = {24'h000000, `SU_RATE_OFS};
  logic ref_clk, rstn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sckOut, sckOeN, txdOut, txdOeN;
  logic rxd, sckLine, txdLine, txEmptyIrq, txDoneIrq, rxFullIrq, rxErrorIrq;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] sendByte, lastByte, prevByte;
  int bad_count;
  int n_compared;
  ////////////////////////////////////////////////////////////////
  // pulled-up lines, driven by the unit only while its enable is low
  assign sckLine = sckOeN ? 1'b1 : sckOut;
  assign txdLine = txdOeN ? 1'b1 : txdOut;
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  serial_unit serial_unit_i (
    .ref_clk(ref_clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .sckIn(sckLine),
    .sckOut(sckOut), .sckOeN(sckOeN), .rxdIn(rxd), .txdOut(txdOut), .txdOeN(txdOeN),
    .txEmptyIrq(txEmptyIrq), .txDoneIrq(txDoneIrq), .rxFullIrq(rxFullIrq),
    .rxErrorIrq(rxErrorIrq)
  );
  serial_peer serial_peer_i (
    .rstn(rstn), .sck(sckLine), .txd(txdLine), .rxd(rxd), .sendByte(sendByte),
    .lastByte(lastByte), .prevByte(prevByte)
  );
  ////////////////////////////////////////////////////////////////
  task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check32
  // write: offer both channels, release each when taken, then await the answer
  task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
    logic awDone = 1'b0;
    logic wDone = 1'b0;
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge ref_clk);
      if (awready === 1'b1) begin
        awDone = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready === 1'b1) begin
        wDone = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge ref_clk);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [31:0] a);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge ref_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge ref_clk);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_read
  // polls one status bit until it reaches the wanted level
  task automatic wait_stat(input int idx, input logic val);
    int n = 0;
    do begin
      axi_read(statA);
      n++;
    end while (rd[idx] !== val && n < 300);
    check32("status poll", {31'h0, val}, {31'h0, rd[idx]});
  endtask : wait_stat
  ////////////////////////////////////////////////////////////////
  task automatic test_reset_map();
    axi_read(statA);
    check32("status at reset", {25'h0, `SU_STAT_RST}, rd);
    axi_read(ctrlA);
    check32("control at reset", {24'h0, `SU_CTRL_RST}, rd);
    axi_read(rateA);
    check32("rate at reset", {24'h0, `SU_RATE_RST}, rd);
    axi_read(32'h00000020);
    check32("unmapped read resp", {30'h0, `SU_RESP_SLVERR}, {30'h0, resp});
    check32("unmapped read data", 32'h0, rd);
    axi_write(32'h00000020, 32'h000000ff);
    check32("unmapped write resp", {30'h0, `SU_RESP_SLVERR}, {30'h0, resp});
  endtask : test_reset_map
  task automatic test_tx_pair();
    axi_write(rateA, 32'h3);
    axi_write(ctrlA, 32'h15);
    axi_read(statA);
    check32("empty before write", 32'h1, {31'h0, rd[0]});
    axi_write(txA, 32'ha5);
    axi_write(statA, 32'h7e);
    wait_stat(0, 1'b1);
    check32("empty request", 32'h1, {31'h0, txEmptyIrq});
    axi_write(txA, 32'h3c);
    axi_write(statA, 32'h7e);
    wait_stat(5, 1'b1);
    check32("first byte", 32'ha5, {24'h0, prevByte});
    check32("second byte", 32'h3c, {24'h0, lastByte});
    check32("done request", 32'h1, {31'h0, txDoneIrq});
    check32("line holds bit 7", 32'h0, {31'h0, txdOut});
    check32("clock parked", 32'h1, {31'h0, sckOut});
    check32("data driven", 32'h0, {31'h0, txdOeN});
    check32("clock driven", 32'h0, {31'h0, sckOeN});
  endtask : test_tx_pair
  task automatic test_rx_overrun();
    sendByte <= 8'h96;
    axi_write(ctrlA, 32'h0a);
    // second frame carries another byte, so a store that should be dropped shows
    repeat (20) @(posedge ref_clk);
    sendByte <= 8'h5b;
    wait_stat(1, 1'b1);
    check32("full request", 32'h1, {31'h0, rxFullIrq});
    axi_read(rxA);
    check32("received byte", 32'h96, rd);
    wait_stat(2, 1'b1);
    check32("full kept", 32'h1, {31'h0, rd[1]});
    check32("error request", 32'h1, {31'h0, rxErrorIrq});
    axi_read(rxA);
    check32("data kept", 32'h96, rd);
    repeat (40) @(posedge ref_clk);
    check32("clock stopped", 32'h1, {31'h0, sckOut});
    axi_write(ctrlA, 32'h0);
    axi_read(statA);
    check32("flags kept", 32'h6, rd & 32'h6);
  endtask : test_rx_overrun
  task automatic test_error_blocks_tx();
    axi_write(ctrlA, 32'h01);
    axi_write(txA, 32'h81);
    axi_write(statA, 32'h7e);
    repeat (40) @(posedge ref_clk);
    axi_read(statA);
    check32("no start while error", 32'h0, {31'h0, rd[0]});
    check32("clock idle", 32'h1, {31'h0, sckOut});
    axi_write(statA, 32'h79);
    wait_stat(5, 1'b1);
    check32("sent after clearing", 32'h81, {24'h0, lastByte});
  endtask : test_error_blocks_tx
  // full duplex: two frames back to back, receive serviced before the second ends
  task automatic test_duplex();
    wait_stat(0, 1'b1);
    wait_stat(5, 1'b1);
    axi_write(ctrlA, 32'h0);
    sendByte <= 8'h6d;
    axi_write(ctrlA, 32'h03);
    axi_write(txA, 32'hc3);
    axi_write(statA, 32'h7e);
    wait_stat(0, 1'b1);
    axi_write(txA, 32'h5a);
    axi_write(statA, 32'h7e);
    sendByte <= 8'h2e;
    wait_stat(1, 1'b1);
    axi_read(rxA);
    check32("duplex first rx", 32'h6d, rd);
    axi_write(statA, 32'h7d);
    wait_stat(5, 1'b1);
    check32("duplex first tx", 32'hc3, {24'h0, prevByte});
    check32("duplex second tx", 32'h5a, {24'h0, lastByte});
    axi_read(rxA);
    check32("duplex second rx", 32'h2e, rd);
    axi_write(statA, 32'h7d);
    axi_write(ctrlA, 32'h0);
  endtask : test_duplex
  task automatic test_dma_auto();
    axi_write(ctrlA, 32'h81);
    axi_write(txA, 32'h42);
    wait_stat(5, 1'b1);
    check32("auto transmit", 32'h42, {24'h0, lastByte});
    sendByte <= 8'he7;
    axi_write(ctrlA, 32'h82);
    wait_stat(1, 1'b1);
    axi_read(rxA);
    check32("auto receive", 32'he7, rd);
    axi_read(statA);
    check32("auto full clear", 32'h0, {31'h0, rd[1]});
    // let the running clock stop on an overrun before disabling, never mid-frame
    wait_stat(2, 1'b1);
    axi_write(ctrlA, 32'h0);
  endtask : test_dma_auto
  ////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    if (bad_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  // cuts a hung run short
  initial begin
    #1000000;
    bad_count++;
    print_verdict();
  end
  initial begin
    {rstn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, wdata, araddr} = 96'h0;
    wstrb = 4'hf;
    sendByte = 8'h00;
    bad_count = 0;
    n_compared = 0;
    repeat (12) @(posedge ref_clk);
    rstn <= 1'b1;
    test_reset_map();
    test_tx_pair();
    test_rx_overrun();
    test_error_blocks_tx();
    test_duplex();
    test_dma_auto();
    print_verdict();
  end
endmodule : serial_unit_tb_top
